// ### bench/afe_spi_command_config_port_test.sv
`timescale 1ns/100ps
// self-checking bench: register model with parity, command effects
module afe_spi_command_config_port_test;
	import afecp_pkg::*;
	logic clk, reset, ce, sclk, cs_n, sdio_i, sdio_o, sdio_oe, alert_oe;
	logic alert_o; // open-collector value of the alert pin
	logic rx, act, ginit, clamp, slp, pres, srp, gcap, ghv, gft;
	logic rsen, disch, cdiv, gso;
	logic [1:0] mmd;
	logic [7:0] ast; // analog status bits
	logic [8:0] v, b, col, rd;
	logic [31:0] seed;
	int fail_count, n_compared, srp_seen, gcap_seen;
	int regs[8]; // model of the register bank

	afecp_master afecp_master_i (.sclk(sclk), .cs_n(cs_n),
		.sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe));
	afecp_top afecp_top_i (.clk(clk), .reset(reset), .ce(ce),
		.sclk(sclk), .cs_n_pin(cs_n), .alert_o(alert_o),
		.alert_oe(alert_oe),
		.sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
		.receive_output_pin(rx), .analog_status(ast),
		.active_mode_in(act), .gain_init_in(ginit), .clamp_on(clamp),
		.sleep_mode(slp), .agc_preserve(pres), .soft_reset_pulse(srp),
		.gain_capture(gcap), .gain_hold_valid(ghv),
		.gain_fast_track(gft), .rssi_out_enable(rsen),
		.signal_level_discharge_switch(disch),
		.carrier_divide_select(cdiv), .gain_signal_option(gso),
		.min_modulation_depth(mmd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// one-cycle pulses are counted, never sampled late
	always @(posedge clk) begin
		if (srp === 1'b1)
			srp_seen++;
		if (gcap === 1'b1)
			gcap_seen++;
	end

	function automatic logic [8:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[8:0];
	endfunction
	function automatic logic [8:0] rowfix(input logic [8:0] x);
		return {x[8:1], ~^x[8:1]};
	endfunction
	// any bad row or column raises the flag
	function automatic logic perr_exp();
		logic [8:0] c;
		logic bad;
		c = 9'h000;
		bad = 1'b0;
		for (int r = 0; r < 7; r++) begin
			c ^= regs[r][8:0];
			bad |= ~^regs[r][8:0];
		end
		return bad | (c != 9'h1ff);
	endfunction

	task automatic check(input string nm, input logic [8:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// execution lands 3-4 clocks after the frame, ten is ample
	task automatic go(input logic [31:0] w, input int n);
		afecp_master_i.xfer(w, n, rd);
		repeat (10) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [8:0] d);
		go({AFECP_WRITE, a, d, 16'h0000}, 16);
		if (a < 7)
			regs[a] = d;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [8:0] e);
		go({AFECP_READ, a, 9'h000, 16'h0000}, 16);
		check("read", rd, e);
	endtask
	task automatic cmd(input afecp_cmd_t c);
		go({c, 13'h0000, 16'h0000}, 16);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// whole run needs about 75 us
	initial begin
		#400000;
		fail_count++;
		$display("watchdog expired");
		complete_run();
	end

	initial begin
		reset = 1'b1;
		ce = 1'b1;
		rx = 1'b1;
		act = 1'b0;
		ginit = 1'b0;
		seed = 32'h0000_0044;
		fail_count = 0;
		n_compared = 0;
		srp_seen = 0;
		gcap_seen = 0;
		regs = '{default: 0};
		ast = 8'(xs());
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (5) @(posedge clk);
		for (int a = 0; a < 8; a++)
			rdc(4'(a), a == 7 ? {ast, 1'b1} : 9'h000);
		check("alert", 9'({alert_o, alert_oe}), 9'h001);
		$display("reset test done");
		// second pass selects signal-strength output
		for (int k = 0; k < 2; k++) begin
			col = 9'h000;
			for (int a = 0; a < 6; a++) begin
				v = xs();
				if (a == 1)
					v[8] = k[0];
				if (a == 2)
					v[8] = 1'b1;
				v = rowfix(v);
				col ^= v;
				wr(4'(a), v);
			end
			wr(ADDR_COL_PAR, rowfix(~col));
			wr(ADDR_STATUS, 9'h0aa);
			wr(4'h9, 9'h155);
			for (int a = 0; a < 10; a++)
				rdc(4'(a), a < 7 ? regs[a][8:0] :
					a == 7 ? {ast, perr_exp()} : 9'h000);
			check("fields", {disch, cdiv, gso, mmd, rsen, sdio_oe, alert_oe,
				1'b0}, {regs[1][8] & regs[2][8], regs[2][7], regs[5][7],
				regs[5][6:5], regs[1][8], ~regs[1][8], 2'b00});
			if (k == 0) begin
				check("rx", 9'(sdio_o), 9'h001);
				rx <= 1'b0;
				repeat (4) @(posedge clk);
				check("rx", 9'(sdio_o), 9'h000);
				rx <= 1'b1;
			end else begin
				// signal output must pause while a frame is on the pins
				fork
					rdc(ADDR_GENERAL, regs[0][8:0]);
					begin
						@(negedge cs_n);
						repeat (5) @(posedge clk);
						check("pause", 9'(rsen), 9'h000);
					end
				join
				check("resume", 9'(rsen), 9'h001);
			end
		end
		$display("register test done");
		v = regs[3][8:0];
		b = rowfix(xs()) ^ 9'h001;
		// trailing part of the second frame must be dropped
		go({AFECP_WRITE, ADDR_UNUSED, b, AFECP_WRITE, ADDR_UNUSED, v}, 26);
		regs[3] = b;
		rdc(ADDR_STATUS, {ast, 1'b1});
		check("alert", 9'(alert_oe), 9'h001);
		go({AFECP_WRITE, ADDR_UNUSED, v, 16'h0000}, 10);
		rdc(ADDR_UNUSED, b);
		go({AFECP_WRITE, ADDR_UNUSED, b, AFECP_WRITE, ADDR_UNUSED, v}, 32);
		regs[3] = v;
		rdc(ADDR_STATUS, {ast, perr_exp()});
		check("alert", 9'(alert_oe), 9'(perr_exp()));
		$display("framing test done");
		@(posedge clk) act <= 1'b1;
		ce <= 1'b0;
		// a frame that lands while frozen waits for the enable
		cmd(AFECP_CLAMP_ON);
		check("freeze", 9'(clamp), 9'h000);
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		check("clamp", 9'(clamp), 9'h001);
		cmd(AFECP_SOFT_RESET);
		check("sreset", {clamp, 8'(srp_seen)}, 9'h101);
		@(posedge clk) act <= 1'b0;
		cmd(AFECP_SOFT_RESET);
		check("sreset", 9'(srp_seen), 9'h001);
		cmd(AFECP_CLAMP_OFF);
		check("clamp", 9'(clamp), 9'h000);
		cmd(AFECP_SLEEP);
		check("sleep", {6'h00, slp, rsen, sdio_o}, 9'h004);
		cmd(AFECP_PRESERVE_ON);
		check("wake", {7'h00, slp, pres}, 9'h001);
		@(posedge clk) ginit <= 1'b1;
		repeat (10) @(posedge clk);
		check("capture", {4'h0, 3'(gcap_seen), ghv, gft}, 9'h006);
		@(posedge clk) ginit <= 1'b0;
		act <= 1'b1;
		cmd(AFECP_SOFT_RESET);
		check("hold", 9'(ghv), 9'h000);
		cmd(AFECP_PRESERVE_OFF);
		@(posedge clk) ginit <= 1'b1;
		repeat (10) @(posedge clk);
		check("track", {7'h00, pres, gft}, 9'h001);
		$display("command test done");
		complete_run();
	end
endmodule // afe_spi_command_config_port_test

// ### bench/afecp_master.sv
`timescale 1ns/100ps
// microcontroller stand-in: serial bus master in clock mode 0,0
module afecp_master import afecp_pkg::*; (
	output logic sclk,
	output logic cs_n,
	output logic sdio_i,
	input wire logic sdio_o,
	input wire logic sdio_oe
);
	logic mdrv; // master drives the data pin
	logic mbit; // bit the master puts out
	logic junk; // floating pin: changes often so no stale value survives
	assign sdio_i = sdio_oe ? sdio_o : (mdrv ? mbit : junk);
	// select held high, clock idles low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mdrv = 1'b0;
		mbit = 1'b0;
		junk = 1'b0;
	end
	always #7 junk = ~junk;
	task automatic xfer(input logic [31:0] w, input int n,
		output logic [8:0] rd);
		logic [2:0] c; // command of the frame in flight
		rd = 9'h000;
		c = 3'h0;
		#3;
		cs_n = 1'b0;
		mdrv = 1'b1;
		mbit = w[31];
		#40;
		for (int i = 0; i < n; i++) begin
			if (i % 16 == 0)
				c = w[31:29];
			#32;
			sclk = 1'b1;
			if (i % 16 > 6)
				rd = {rd[7:0], sdio_i};
			#32;
			sclk = 1'b0;
			w = {w[30:0], w[31]};
			mbit = w[31];
			// release the pin while the device answers a read
			mdrv = !(c == AFECP_READ && i % 16 >= 6 && i % 16 < 15);
		end
		#40;
		cs_n = 1'b1;
		mdrv = 1'b0;
	endtask
endmodule // afecp_master

// ### verilog/afecp_link.sv
`timescale 1ns/100ps
// serial-clock side: shifts frames in, drives read data out
module afecp_link import afecp_pkg::*; (
	input wire logic sclk,
	input wire logic reset,
	input wire logic link_rst,
	input wire logic sdi,
	input wire logic [71:0] reg_bank,
	output logic [15:0] frame_word,
	output logic frame_tgl,
	output logic sdo,
	output logic sdo_oe
);
	logic [3:0] cnt_r; // rising edges taken in this frame
	logic [14:0] shift_r; // bits of the frame so far
	logic [2:0] cmd_r; // command of the frame in flight
	logic [3:0] addr_r; // address of the frame in flight
	logic [8:0] rd_word; // addressed register
	logic [6:0] base; // bit offset into the bank
	logic [3:0] bit_idx; // data bit to present next

	// count and shift; chip select high clears the frame state
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			cnt_r <= 4'h0;
			shift_r <= 15'h0000;
			cmd_r <= 3'h0;
			addr_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			shift_r <= {shift_r[13:0], sdi};
			if (cnt_r == CNT_CMD_LAST)
				cmd_r <= {shift_r[1:0], sdi};
			if (cnt_r == CNT_ADDR_LAST)
				addr_r <= {shift_r[2:0], sdi};
		end
	end

	// frame handed over only on its sixteenth edge; not cleared by cs
	// so the toggle never glitches for the other domain
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			frame_word <= 16'h0000;
			frame_tgl <= 1'b0;
		end else if (cnt_r == CNT_FRAME_LAST) begin
			frame_word <= {shift_r, sdi};
			frame_tgl <= ~frame_tgl;
		end
	end

	// bank words only change between frames, so the mux is quasi-static
	always_comb begin
		base = 7'(addr_r[2:0]) * 7'h09;
		rd_word = addr_r[3] ? 9'h000 : reg_bank[base +: 9];
		bit_idx = CNT_FRAME_LAST - cnt_r;
	end

	// read data changes on the falling edge
	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else if (cmd_r == AFECP_READ && cnt_r >= CNT_DATA_FIRST) begin
			sdo <= rd_word[bit_idx];
			sdo_oe <= 1'b1;
		end else begin
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end
	end

	frame_hand_a: assert property (
		@(posedge sclk) disable iff (reset)
		cnt_r == CNT_FRAME_LAST |=> frame_tgl != $past(frame_tgl))
		else $error("frame not handed over on sixteenth edge");

	read_drive_a: assert property (
		@(negedge sclk) disable iff (link_rst)
		sdo_oe |-> $past(cmd_r) == AFECP_READ &&
		$past(cnt_r) >= CNT_DATA_FIRST)
		else $error("data pin driven outside a read");
endmodule // afecp_link

// ### verilog/afecp_pkg.sv
package afecp_pkg;
	// frame layout: command, address, data byte plus row parity
	localparam int unsigned CMD_BITS = 3;
	localparam int unsigned ADDR_BITS = 4;
	localparam int unsigned REG_BITS = 9;
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned NUM_REGS = 8;
	localparam int unsigned NUM_CFG = 7;
	// edge counts inside a frame (rising edges already taken)
	localparam logic [3:0] CNT_CMD_LAST = 4'h2;
	localparam logic [3:0] CNT_ADDR_LAST = 4'h6;
	localparam logic [3:0] CNT_DATA_FIRST = 4'h7;
	localparam logic [3:0] CNT_FRAME_LAST = 4'hf;
	// field positions inside the frame word
	localparam int unsigned FR_CMD_HI = 15;
	localparam int unsigned FR_CMD_LO = 13;
	localparam int unsigned FR_ADDR_HI = 12;
	localparam int unsigned FR_ADDR_LO = 9;
	localparam int unsigned FR_DATA_HI = 8;
	// register offsets
	localparam logic [3:0] ADDR_GENERAL = 4'h0;
	localparam logic [3:0] ADDR_TUNE_OUT = 4'h1;
	localparam logic [3:0] ADDR_DISCH_CLK = 4'h2;
	localparam logic [3:0] ADDR_UNUSED = 4'h3;
	localparam logic [3:0] ADDR_SENSE = 4'h4;
	localparam logic [3:0] ADDR_MOD_GAIN = 4'h5;
	localparam logic [3:0] ADDR_COL_PAR = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;
	// field positions inside registers
	localparam int unsigned OUTSEL_RSSI_BIT = 8;
	localparam int unsigned DISCH_BIT = 8;
	localparam int unsigned CARRIER_DIVIDE_SELECT_BIT = 7;
	localparam int unsigned GAINSIG_BIT = 7;
	localparam int unsigned MIN_MODULATION_DEPTH_HI = 6;
	localparam int unsigned MIN_MODULATION_DEPTH_LO = 5;
	localparam int unsigned PARITY_FLAG_BIT = 0;
	// reset value of every configuration register
	localparam logic [8:0] REG_RESET = 9'h000;
	// serial commands
	typedef enum logic [2:0] {
		AFECP_CLAMP_ON = 3'b000,
		AFECP_CLAMP_OFF = 3'b001,
		AFECP_SLEEP = 3'b010,
		AFECP_PRESERVE_ON = 3'b011,
		AFECP_PRESERVE_OFF = 3'b100,
		AFECP_SOFT_RESET = 3'b101,
		AFECP_READ = 3'b110,
		AFECP_WRITE = 3'b111
	} afecp_cmd_t;
endpackage

// ### verilog/afecp_sync.sv
`timescale 1ns/100ps
// two flop level synchroniser, one lane per bit
module afecp_sync import afecp_pkg::*; #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// first stage, read only by the second stage
	logic [WIDTH-1:0] meta_r;

	// both stages freeze with the clock enable
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // afecp_sync

// ### verilog/afecp_top.sv
`timescale 1ns/100ps
module afecp_top import afecp_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic sclk,
	input wire logic cs_n_pin,
	output logic alert_o,
	output logic alert_oe,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	input wire logic receive_output_pin,
	input wire logic [7:0] analog_status,
	input wire logic active_mode_in,
	input wire logic gain_init_in,
	output logic clamp_on,
	output logic sleep_mode,
	output logic agc_preserve,
	output logic soft_reset_pulse,
	output logic gain_capture,
	output logic gain_hold_valid,
	output logic gain_fast_track,
	output logic rssi_out_enable,
	output logic signal_level_discharge_switch,
	output logic carrier_divide_select,
	output logic gain_signal_option,
	output logic [1:0] min_modulation_depth
);
	logic [8:0] regs_r [NUM_CFG]; // configuration words 0..6
	logic [8:0] status_r; // read-only status word
	logic [71:0] reg_bank; // flattened for the link side
	logic [NUM_CFG-1:0] row_bad; // row parity failures
	logic [REG_BITS-1:0] col_bad; // column parity failures
	logic parity_err_r; // registered parity error
	logic link_rst; // clears link frame state
	logic [15:0] frame_word; // last whole frame
	logic frame_tgl; // flips once per whole frame
	logic link_sdo; // read data from link side
	logic link_oe; // link side drives data pin
	logic [12:0] sync_in; // raw asynchronous levels
	logic [12:0] sync_q; // synchronised levels
	logic cs_hi_s; // chip select high, synchronised
	logic tgl_s; // frame toggle, synchronised
	logic tgl_d_r; // previous synchronised toggle
	logic rx_s; // receive data, synchronised
	logic active_s; // active mode, synchronised
	logic init_s; // gain initialisation period
	logic init_d_r; // previous initialisation level
	logic [7:0] astat_s; // analog status bits
	logic frame_evt; // one whole frame to execute
	afecp_cmd_t cmd; // command of that frame
	logic [3:0] addr; // address of that frame
	logic [8:0] wdata; // data byte and parity
	logic rx_out_r; // receive data as driven
	logic rssi_mode; // signal-strength output chosen

	// select high drops a partial frame
	assign link_rst = cs_n_pin | reset;
	assign sync_in = {cs_n_pin, frame_tgl, receive_output_pin,
		active_mode_in, gain_init_in, analog_status};

	// every foreign level but the frame word passes two flops here
	afecp_sync #(
		.WIDTH(13)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.async_in(sync_in),
		.sync_out(sync_q)
	);

	assign cs_hi_s = sync_q[12];
	assign tgl_s = sync_q[11];
	assign rx_s = sync_q[10];
	assign active_s = sync_q[9];
	assign init_s = sync_q[8];
	assign astat_s = sync_q[7:0];

	// serial-clock domain; the frame word is stable for a full frame,
	// far longer than the toggle takes to cross
	afecp_link u_link (
		.sclk(sclk),
		.reset(reset),
		.link_rst(link_rst),
		.sdi(sdio_i),
		.reg_bank(reg_bank),
		.frame_word(frame_word),
		.frame_tgl(frame_tgl),
		.sdo(link_sdo),
		.sdo_oe(link_oe)
	);

	// toggle edge marks a frame ready in this domain
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			tgl_d_r <= 1'b0;
		else if (ce)
			tgl_d_r <= tgl_s;
	end

	assign frame_evt = ce & (tgl_s ^ tgl_d_r);
	assign cmd = afecp_cmd_t'(frame_word[FR_CMD_HI:FR_CMD_LO]);
	assign addr = frame_word[FR_ADDR_HI:FR_ADDR_LO];
	assign wdata = frame_word[FR_DATA_HI:0];

	// configuration words; power-on clears them all
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CFG; i++)
				regs_r[i] <= REG_RESET;
		end else if (frame_evt && cmd == AFECP_WRITE) begin
			if (addr < ADDR_STATUS)
				regs_r[addr[2:0]] <= wdata;
		end
	end

	// status mirrors the analog side plus the parity flag; no write path
	// held while select is low, so the link shifts out one steady word
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			status_r <= REG_RESET;
		else if (ce && cs_hi_s)
			status_r <= {astat_s, parity_err_r};
	end

	// parity check, one row per entry of the first loop, one column per entry of the second
	genvar g;
	generate
		for (g = 0; g < NUM_CFG; g++) begin : g_row
			assign row_bad[g] = ~(^regs_r[g]);
			assign reg_bank[g*9 +: 9] = regs_r[g];
		end
		for (g = 0; g < REG_BITS; g++) begin : g_col
			assign col_bad[g] = ~(regs_r[0][g] ^ regs_r[1][g] ^
				regs_r[2][g] ^ regs_r[3][g] ^ regs_r[4][g] ^
				regs_r[5][g] ^ regs_r[6][g]);
		end
	endgenerate
	assign reg_bank[71:63] = status_r;

	// error is registered so the flag and the alert agree
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			parity_err_r <= 1'b1;
		else if (ce)
			parity_err_r <= (|row_bad) | (|col_bad);
	end

	assign alert_o = 1'b0;
	assign alert_oe = cs_n_pin & parity_err_r;

	// modulation clamp; nothing else touches it
	// soft reset keeps clamp
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			clamp_on <= 1'b0;
		else if (frame_evt) begin
			if (cmd == AFECP_CLAMP_ON)
				clamp_on <= 1'b1;
			else if (cmd == AFECP_CLAMP_OFF)
				clamp_on <= 1'b0;
		end
	end

	// sleep entered by its command, left by any other
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sleep_mode <= 1'b0;
		else if (frame_evt)
			sleep_mode <= (cmd == AFECP_SLEEP);
	end

	// gain preservation switch
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			agc_preserve <= 1'b0;
		else if (frame_evt) begin
			if (cmd == AFECP_PRESERVE_ON)
				agc_preserve <= 1'b1;
			else if (cmd == AFECP_PRESERVE_OFF)
				agc_preserve <= 1'b0;
		end
	end

	// one-cycle soft reset for the analog blocks
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			soft_reset_pulse <= 1'b0;
		else if (ce)
			soft_reset_pulse <= frame_evt && cmd == AFECP_SOFT_RESET &&
				active_s;
	end

	// capture strobe at the start of each initialisation period while preservation is on
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			init_d_r <= 1'b0;
			gain_capture <= 1'b0;
		end else if (ce) begin
			init_d_r <= init_s;
			gain_capture <= agc_preserve & init_s & ~init_d_r;
		end
	end

	// held gain valid until soft reset or preservation off; a capture in the same cycle
	// as the discard wins, so the new period is not lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			gain_hold_valid <= 1'b0;
		else if (ce) begin
			if (gain_capture)
				gain_hold_valid <= 1'b1;
			else if (soft_reset_pulse || !agc_preserve)
				gain_hold_valid <= 1'b0;
		end
	end

	assign gain_fast_track = ~agc_preserve & init_s;

	// output selection fields
	assign rssi_mode = regs_r[ADDR_TUNE_OUT[2:0]][OUTSEL_RSSI_BIT];
	assign rssi_out_enable = rssi_mode & cs_hi_s & ~sleep_mode;
	assign signal_level_discharge_switch = rssi_mode &
		regs_r[ADDR_DISCH_CLK[2:0]][DISCH_BIT];
	assign carrier_divide_select = regs_r[ADDR_DISCH_CLK[2:0]][CARRIER_DIVIDE_SELECT_BIT];
	assign gain_signal_option = regs_r[ADDR_MOD_GAIN[2:0]][GAINSIG_BIT];
	assign min_modulation_depth =
		regs_r[ADDR_MOD_GAIN[2:0]][MIN_MODULATION_DEPTH_HI:MIN_MODULATION_DEPTH_LO];

	// receive data held low in sleep; sleep cuts the output path too
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rx_out_r <= 1'b0;
		else if (ce)
			rx_out_r <= rx_s & ~sleep_mode;
	end

	assign sdio_o = cs_n_pin ? rx_out_r : link_sdo;
	assign sdio_oe = cs_n_pin ? ~rssi_mode : link_oe;

	write_reg_a: assert property (
		@(posedge clk) disable iff (reset)
		frame_evt && cmd == AFECP_WRITE && addr == ADDR_DISCH_CLK
		|=> regs_r[2] == $past(wdata))
		else $error("register write not stored");

	status_keep_a: assert property (
		@(posedge clk) disable iff (reset)
		!reset && ce && cs_hi_s |=>
		status_r == {$past(astat_s), $past(parity_err_r)})
		else $error("status word not from its sources");

	status_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		!cs_hi_s |=> $stable(status_r))
		else $error("status word moved during a transfer");

	parity_alert_a: assert property (
		@(posedge clk) disable iff (reset)
		ce && ((|row_bad) || (|col_bad)) |=> parity_err_r &&
		(alert_oe == cs_n_pin))
		else $error("parity error without alert");

	clamp_hold_a: assert property (
		@(posedge clk) disable iff (reset)
		$changed(clamp_on) |-> $past(frame_evt) &&
		($past(cmd) == AFECP_CLAMP_ON || $past(cmd) == AFECP_CLAMP_OFF))
		else $error("clamp changed without clamp command");

	sleep_wake_a: assert property (
		@(posedge clk) disable iff (reset)
		frame_evt && cmd != AFECP_SLEEP |=> !sleep_mode)
		else $error("sleep not left on other command");

	soft_gate_a: assert property (
		@(posedge clk) disable iff (reset)
		soft_reset_pulse |-> $past(frame_evt) && $past(active_s) &&
		$past(cmd) == AFECP_SOFT_RESET)
		else $error("soft reset outside active mode");

	discharge_a: assert property (
		@(posedge clk) disable iff (reset)
		signal_level_discharge_switch |-> rssi_mode)
		else $error("discharge switch outside signal mode");

	preserve_cmd_a: assert property (
		@(posedge clk) disable iff (reset)
		frame_evt && cmd == AFECP_PRESERVE_OFF |=> !agc_preserve[*2])
		else $error("preservation not turned off");

	sleep_quiet_a: assert property (
		@(posedge clk) disable iff (reset)
		ce && sleep_mode |=> !rx_out_r)
		else $error("receive data passed during sleep");

	capture_win_a: assert property (
		@(posedge clk) disable iff (reset)
		ce && gain_capture |=> gain_hold_valid)
		else $error("captured gain not marked valid");

	soft_ignore_a: assert property (
		@(posedge clk) disable iff (reset)
		frame_evt && cmd == AFECP_SOFT_RESET && !active_s |=>
		!soft_reset_pulse)
		else $error("soft reset issued outside active mode");
endmodule // afecp_top
